// ===== rtl/lpm_consts.svh
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
// How it works
// [R01] Option picks full stop or halt
// [R02] Full stop gates oscillator and watchdog
// [R03] Stop entry clears timer flags, enables
// [R04] Any entry clears mask, sets external enable
// [R05] Other state left untouched in stop
// [R06] Stop wakes on external irq or reset
// [R07] Stop exit waits 224 or 4064 cycles
// [R08] Halt gates cpu clock, timers run
// [R09] Halt ends on timer, irq, reset
// [R10] Halt exit delay continues from counter
// [R11] Wait gates cpu clock, timers run
// [R12] Enabled timer interrupt ends wait
// [R13] Wait ends on irq or reset
// [R14] Watchdog runs except in full stop
// [R15] Systems with watchdog should use halt
// [R16] Disable watchdog for long waits, stop
// [R17] External enable gates external flag
// [R18] Reset wake runs normal reset sequence

// ****************************************
// Register map (APB byte offsets)
// ****************************************
`define LPM_CTRL_ADDR 12'h000
`define LPM_STAT_ADDR 12'h004
`define LPM_IRQST_ADDR 12'h008
`define LPM_IRQMSK_ADDR 12'h00C

// ****************************************
// Field positions and reset values
// ****************************************
`define LPM_CTRL_OVF_FLAG 0
`define LPM_CTRL_PER_FLAG 1
`define LPM_CTRL_OVF_EN 2
`define LPM_CTRL_PER_EN 3
`define LPM_CTRL_EXT_EN 4
`define LPM_CTRL_EXT_FLAG 5
`define LPM_CTRL_IMASK 6
`define LPM_CTRL_RESET 7'h50
`define LPM_EV_ENTER 0
`define LPM_EV_WAKE 1

// ****************************************
// Timing counts (in system clock cycles)
// ****************************************
`define LPM_DELAY_SHORT 12'd224
`define LPM_DELAY_LONG 12'd4064
`endif

// ===== rtl/lpm_pkg.sv
package lpm_pkg;
  // Low-power state machine
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b011,
    ST_DELAY = 3'b100
  } lpm_state_t;
endpackage

// ===== rtl/low_power_mode_control.sv
`include "lpm_consts.svh"
module low_power_mode_control #(
  parameter bit STOP_IS_HALT = 1'b0, // Build option
  parameter bit LONG_DELAY = 1'b1, // Build option
  parameter bit WATCHDOG_ON = 1'b1 // Build option
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic resetn, // Async reset, low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic stopInstr, // Cpu executes stop, pulse
  input wire logic waitInstr, // Cpu executes wait, pulse
  input wire logic extIrqPin, // External request pin
  input wire logic timerOverflowEvt, // Timer overflow, pulse
  input wire logic periodicEvt, // Periodic tick, pulse
  input wire logic timer1Irq, // Second timer irq level
  output logic cpuClkEn, // Processor clock gate
  output logic oscEn, // Oscillator enable
  output logic watchdogRun, // Watchdog count enable
  output logic resumeAtReset, // Restart via reset vector
  output logic timerIrq, // Timer interrupt to cpu
  output logic extIrq, // External interrupt to cpu
  output logic irq // Block interrupt line
);
  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic irqMeta, irqSync; // Two stage sync
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqMeta <= 1'b0;
      irqSync <= 1'b0;
    end else begin
      irqMeta <= extIrqPin;
      irqSync <= irqMeta;
    end
  end

  // ****************************************
  // Register bus decode
  // ****************************************
  logic wrEn; // Write in access phase
  logic [11:0] addr; // Byte address
  assign wrEn = psel && penable && pwrite;
  assign addr = paddr;

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] b);
    hit = (a == b);
  endfunction

  // ****************************************
  // State and control
  // ****************************************
  lpm_pkg::lpm_state_t state, next_state; // Mode
  logic [6:0] ctrl, next_ctrl; // Timer and irq bits
  logic [11:0] delayCnt, next_delayCnt; // Stabilisation
  logic [1:0] evSt, next_evSt; // Sticky events
  logic [1:0] evMsk, next_evMsk; // Event mask
  logic [31:0] next_prdata; // Read data
  logic next_timerIrq, next_extIrq, next_irq; // Outputs
  logic next_cpuClkEn, next_oscEn, next_wdRun; // Gates
  logic extPending, timerPending, wake; // Wake terms
  logic [11:0] delayMax; // Selected delay
  logic [1:0] evSet; // Event pulses

  assign delayMax = LONG_DELAY ? `LPM_DELAY_LONG : `LPM_DELAY_SHORT; // R07

  // ****************************************
  // Next values for mode, bits and counter
  // ****************************************
  // One process owns every piece of mode state, so
  // software writes, hardware sets and mode entry
  // side effects resolve in a single fixed order:
  // software first, hardware events next, mode
  // entry last.
  always_comb begin
    // Default: everything holds
    next_state = state;
    next_ctrl = ctrl;
    next_delayCnt = delayCnt;
    next_evSt = evSt;
    next_evMsk = evMsk;
    evSet = 2'b00;

    // Software writes to control bits
    if (wrEn && hit(addr, `LPM_CTRL_ADDR)) begin
      next_ctrl = pwdata[6:0];
    end
    // Software writes to event mask
    if (wrEn && hit(addr, `LPM_IRQMSK_ADDR)) begin
      next_evMsk = pwdata[1:0];
    end

    // Hardware flag sets win over software clears; a clear
    // in the same cycle would lose a real request
    if (irqSync) begin
      next_ctrl[`LPM_CTRL_EXT_FLAG] = 1'b1;
    end
    // Timers run unless oscillator is off
    if (state != lpm_pkg::ST_STOP) begin
      if (timerOverflowEvt) begin
        next_ctrl[`LPM_CTRL_OVF_FLAG] = 1'b1;
      end
      if (periodicEvt) begin
        next_ctrl[`LPM_CTRL_PER_FLAG] = 1'b1;
      end
    end

    // Gated external request
    extPending = next_ctrl[`LPM_CTRL_EXT_FLAG] &&
      next_ctrl[`LPM_CTRL_EXT_EN]; // R17
    // Any enabled timer source; second timer is a level
    timerPending = timer1Irq ||
      (next_ctrl[`LPM_CTRL_OVF_FLAG] &&
       next_ctrl[`LPM_CTRL_OVF_EN]) ||
      (next_ctrl[`LPM_CTRL_PER_FLAG] &&
       next_ctrl[`LPM_CTRL_PER_EN]);
    wake = 1'b0;

    case (state)
      lpm_pkg::ST_RUN: begin
        // Counter free-runs so halt exit is arbitrary
        next_delayCnt = (delayCnt >= delayMax - 12'd1) ? 12'd0
          : delayCnt + 12'd1; // R10
        if (stopInstr || waitInstr) begin
          // Every entry opens the external wake path
          next_ctrl[`LPM_CTRL_IMASK] = 1'b0; // R04
          next_ctrl[`LPM_CTRL_EXT_EN] = 1'b1; // R04
          evSet[`LPM_EV_ENTER] = 1'b1;
          if (waitInstr) begin
            next_state = lpm_pkg::ST_WAIT; // R11
          end else if (STOP_IS_HALT) begin
            next_state = lpm_pkg::ST_HALT; // R01 R08
          end else begin
            next_state = lpm_pkg::ST_STOP; // R01 R02
            // These four bits clear; mask cleared and ext enable set above, rest kept
            next_ctrl[`LPM_CTRL_OVF_FLAG] = 1'b0; // R03 R05
            next_ctrl[`LPM_CTRL_PER_FLAG] = 1'b0; // R03
            next_ctrl[`LPM_CTRL_OVF_EN] = 1'b0; // R03
            next_ctrl[`LPM_CTRL_PER_EN] = 1'b0; // R03
          end
        end
      end

      lpm_pkg::ST_WAIT: begin
        // Timer or external request ends wait
        if (timerPending || extPending) begin // R12 R13
          next_state = lpm_pkg::ST_RUN;
          wake = 1'b1;
        end
      end

      lpm_pkg::ST_HALT: begin
        // Counter keeps running, exit delay is unknown
        next_delayCnt = (delayCnt >= delayMax - 12'd1) ? 12'd0
          : delayCnt + 12'd1;
        if (timerPending || extPending) begin // R09
          next_state = lpm_pkg::ST_DELAY; // R10
          wake = 1'b1;
        end
      end

      lpm_pkg::ST_STOP: begin
        // Only the external request wakes full stop;
        // timers are frozen so they cannot help here
        if (extPending) begin // R06
          next_state = lpm_pkg::ST_DELAY;
          next_delayCnt = 12'd0; // R07
          wake = 1'b1;
        end
      end

      lpm_pkg::ST_DELAY: begin
        // Hold cpu clock until counter reaches end
        if (delayCnt >= delayMax - 12'd1) begin // R07 R10
          next_state = lpm_pkg::ST_RUN;
          next_delayCnt = 12'd0;
        end else begin
          next_delayCnt = delayCnt + 12'd1;
        end
      end

      default: begin
        // Illegal code: fall back to run
        next_state = lpm_pkg::ST_RUN;
      end
    endcase

    // Sticky event bits, written one to clear
    evSet[`LPM_EV_WAKE] = wake;
    if (wrEn && hit(addr, `LPM_IRQST_ADDR)) begin
      next_evSt = evSt & ~pwdata[1:0];
    end
    next_evSt = next_evSt | evSet; // Set beats clear
  end

  // Output and read data decode
  always_comb begin
    next_cpuClkEn = (next_state == lpm_pkg::ST_RUN); // R08 R11
    next_oscEn = (next_state != lpm_pkg::ST_STOP); // R02
    next_wdRun = WATCHDOG_ON &&
      (next_state != lpm_pkg::ST_STOP); // R14
    next_timerIrq = timerPending && !next_ctrl[`LPM_CTRL_IMASK];
    next_extIrq = extPending && !next_ctrl[`LPM_CTRL_IMASK];
    next_irq = |(next_evSt & next_evMsk);
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit(addr, `LPM_CTRL_ADDR)) begin
        next_prdata = {25'h0, ctrl};
      end else if (hit(addr, `LPM_STAT_ADDR)) begin
        next_prdata = {25'h0, delayCnt[3:0], state};
      end else if (hit(addr, `LPM_IRQST_ADDR)) begin
        next_prdata = {30'h0, evSt};
      end else if (hit(addr, `LPM_IRQMSK_ADDR)) begin
        next_prdata = {30'h0, evMsk};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end else begin
      next_prdata = prdata;
    end
  end

  // Register all state; reset restarts at run
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= lpm_pkg::ST_RUN; // R18
      ctrl <= `LPM_CTRL_RESET;
      delayCnt <= 12'd0;
      evSt <= 2'b00;
      evMsk <= 2'b00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpuClkEn <= 1'b1;
      oscEn <= 1'b1;
      watchdogRun <= 1'b0;
      resumeAtReset <= 1'b1;
      timerIrq <= 1'b0;
      extIrq <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      delayCnt <= next_delayCnt;
      evSt <= next_evSt;
      evMsk <= next_evMsk;
      prdata <= next_prdata;
      // Ready in the first cycle of the access phase
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit(addr, `LPM_CTRL_ADDR) ||
        hit(addr, `LPM_STAT_ADDR) || hit(addr, `LPM_IRQST_ADDR) ||
        hit(addr, `LPM_IRQMSK_ADDR));
      cpuClkEn <= next_cpuClkEn;
      oscEn <= next_oscEn;
      watchdogRun <= next_wdRun;
      resumeAtReset <= 1'b0; // R18
      timerIrq <= next_timerIrq;
      extIrq <= next_extIrq;
      irq <= next_irq;
    end
  end
endmodule

// ===== test/cpu_core_model.sv
module cpu_core_model (
  input wire logic clk_sys, // System clock
  input wire logic cpuClkEn, // Cpu clock gate
  output logic stopInstr, // Stop executed
  output logic waitInstr // Wait executed
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    stopInstr = 1'b0;
    waitInstr = 1'b0;
  end
  // Waits are kept far below the watchdog timeout
  // Full stop is used only to prove the stop path
  // One pulse, only while the cpu clock runs; a gated cpu executes nothing
  task automatic exec(input bit isStop);
    @(posedge clk_sys);
    while (cpuClkEn !== 1'b1) @(posedge clk_sys);
    if (isStop) begin
      stopInstr <= 1'b1;
    end else begin
      waitInstr <= 1'b1;
    end
    @(posedge clk_sys);
    stopInstr <= 1'b0;
    waitInstr <= 1'b0;
  endtask
endmodule

// ===== test/low_power_mode_control_sva.sv
module low_power_mode_control_sva #(
  parameter bit LONG_DELAY = 1'b1 // Delay option
) (
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic stopInstr, // Stop pulse
  input wire logic extIrqPin, // Ext pin
  input wire logic cpuClkEn, // Cpu gate
  input wire logic oscEn, // Osc enable
  input wire logic watchdogRun, // Watchdog run
  input wire logic resumeAtReset, // Reset path
  input wire logic extIrq // Ext irq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = LONG_DELAY ? 4064 : 224;
  int dly; // Cycles since osc restart
  logic fromStop; // Leaving full stop
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Count only after a real stop; wait exits must not reach it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dly <= 0;
      fromStop <= 1'b0;
    end else begin
      fromStop <= !oscEn || (fromStop && !cpuClkEn);
      dly <= (fromStop && oscEn) ? dly + 1 : 0;
    end
  end
  property p_ans; psel && !penable |=> pready && penable; endproperty
  a_ans: assert property (p_ans) else $error("ready missing");
  property p_qual; pready || pslverr |-> psel && penable; endproperty
  a_qual: assert property (p_qual) else $error("stray ready");
  property p_stop;
    stopInstr && cpuClkEn && !extIrqPin |-> ##3 !cpuClkEn && !oscEn;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");
  property p_wdOff; !oscEn [*2] |-> !watchdogRun; endproperty
  a_wdOff: assert property (p_wdOff) else $error("watchdog runs");
  property p_wdOn; oscEn [*3] |-> watchdogRun; endproperty
  a_wdOn: assert property (p_wdOn) else $error("watchdog idle");
  property p_hold; (!oscEn && !extIrqPin) [*4] |=> !oscEn; endproperty
  a_hold: assert property (p_hold) else $error("stray wake");
  property p_dly;
    $rose(cpuClkEn) && fromStop |-> dly > DLY - 3 && dly < DLY + 4;
  endproperty
  a_dly: assert property (p_dly) else $error("bad restart delay");
  property p_rst; $rose(resetn) |-> resumeAtReset ##1 !resumeAtReset;
  endproperty
  a_rst: assert property (p_rst) else $error("no reset path");
  property p_ext; (!cpuClkEn && extIrqPin) [*4] |-> ##[0:4] extIrq;
  endproperty
  a_ext: assert property (p_ext) else $error("ext irq blocked");
endmodule
bind low_power_mode_control low_power_mode_control_sva #(
  .LONG_DELAY(LONG_DELAY)
) i_sva (.*);

// ===== test/tb_low_power_mode_control.sv
`include "lpm_consts.svh"
module tb_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, extIrqPin = 1'b0, timer1Irq = 1'b0;
  logic timerOverflowEvt = 1'b0, periodicEvt = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, stopInstr, waitInstr, cpuClkEn, oscEn, err;
  logic watchdogRun, resumeAtReset, timerIrq, extIrq, irq;
  int num_errors = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  // Short delay option keeps the run brief
  low_power_mode_control #(.LONG_DELAY(1'b0)) i_dut (.*);
  cpu_core_model i_cpu (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, with no cycle limit
  task automatic apb(input logic wr, input logic [11:0] a, input int d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic evt(input bit ovf, input bit per);
    @(posedge clk_sys);
    timerOverflowEvt <= ovf;
    periodicEvt <= per;
    @(posedge clk_sys);
    timerOverflowEvt <= 1'b0;
    periodicEvt <= 1'b0;
  endtask
  task automatic wake(output int c);
    c = 0;
    while (cpuClkEn !== 1'b1 && c < 5000) begin
      @(posedge clk_sys);
      c++;
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    finish_test();
  end
  initial begin
    int c;
    logic [31:0] d;
    void'($urandom(32'h2226));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b0, `LPM_CTRL_ADDR, 0);
    chk(rd, 32'h50);
    repeat (4) begin
      d = $urandom & 32'h3;
      apb(1'b1, `LPM_IRQMSK_ADDR, d);
      apb(1'b0, `LPM_IRQMSK_ADDR, 0);
      chk(rd, d);
    end
    apb(1'b1, `LPM_IRQMSK_ADDR, 0);
    apb(1'b0, 12'h100, 0);
    chk({rd[0], err}, 2'b01);
    // Wait: disabled timer source ignored, enabled one wakes
    apb(1'b1, `LPM_CTRL_ADDR, 32'h58);
    i_cpu.exec(1'b0);
    repeat (4) @(posedge clk_sys);
    chk({cpuClkEn, oscEn, watchdogRun}, 3'b011);
    evt(1'b1, 1'b0);
    repeat ($urandom_range(30, 10)) @(posedge clk_sys);
    chk(cpuClkEn, 1'b0);
    evt(1'b0, 1'b1);
    wake(c);
    chk(c < 10, 1'b1);
    chk(timerIrq, 1'b1);
    apb(1'b0, `LPM_CTRL_ADDR, 0);
    chk(rd & 32'h58, 32'h18);
    apb(1'b0, `LPM_IRQST_ADDR, 0);
    chk(rd & 32'h3, 32'h3);
    chk(irq, 1'b0);
    apb(1'b1, `LPM_IRQMSK_ADDR, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    apb(1'b1, `LPM_IRQST_ADDR, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    // Full stop with timer requests pending
    apb(1'b1, `LPM_CTRL_ADDR, 32'h5C);
    evt(1'b1, 1'b1);
    i_cpu.exec(1'b1);
    repeat ($urandom_range(8, 4)) @(posedge clk_sys);
    chk({oscEn, watchdogRun}, 2'b00);
    evt(1'b1, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk({oscEn, cpuClkEn}, 2'b00);
    extIrqPin <= 1'b1;
    wake(c);
    chk(c > 224 && c < 236, 1'b1);
    chk(extIrq, 1'b1);
    extIrqPin <= 1'b0;
    apb(1'b0, `LPM_CTRL_ADDR, 0);
    chk(rd & 32'h5C, 32'h10);
    // Reset while waiting takes the reset path
    apb(1'b1, `LPM_CTRL_ADDR, 32'h10);
    i_cpu.exec(1'b0);
    repeat (4) @(posedge clk_sys);
    chk(cpuClkEn, 1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({resumeAtReset, cpuClkEn}, 2'b11);
    resetn <= 1'b1;
    apb(1'b0, `LPM_CTRL_ADDR, 0);
    chk(rd, 32'h50);
    finish_test();
  end
endmodule
